// ==== rtl/audio_serial_port_clocking_pkg.sv ====
package audio_serial_port_clocking_pkg;
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] RATIO_OFF = 8'h08;
  localparam logic [7:0] LEFT_OFF = 8'h0C;
  localparam logic [7:0] RIGHT_OFF = 8'h10;
  // Control field positions.
  localparam int PDN_BIT = 0;
  localparam int MASTER_BIT = 1;
  localparam int HALVE_BIT = 2;
  localparam int AUTO_BIT = 3;
  localparam int SPEED_LSB = 4;
  localparam int TRI_BIT = 6;
  localparam int FMT_LSB = 7;
  localparam int WL_LSB = 9;
  localparam int CPF_LSB = 12;
  // Power-down set, auto-detect on, single speed, pump setting 7.
  localparam logic [15:0] CTRL_RST = 16'h7029;
  // Speed and format encodings.
  localparam logic [1:0] SPD_QUARTER = 2'h0;
  localparam logic [1:0] SPD_HALF = 2'h1;
  localparam logic [1:0] SPD_SINGLE = 2'h2;
  localparam logic [1:0] SPD_DOUBLE = 2'h3;
  localparam logic [1:0] FMT_LJ = 2'h0;
  localparam logic [1:0] FMT_I2S = 2'h1;
  localparam logic [1:0] FMT_RJ = 2'h2;
  // Timing.
  localparam int CLK_MHZ = 100;
  localparam int HW_TIMEOUT_MS = 10;
  localparam int HW_TIMEOUT_CYC = HW_TIMEOUT_MS * 1000 * 1000 * CLK_MHZ / 1000;
  localparam int REF_SETTLE_CYC = 256;
  localparam int AMP_SETTLE_CYC = 256;
  localparam int MCLK_LOSS_CYC = 64;
  localparam logic [11:0] FRAME_MAX_TICKS = 12'hFFF;
endpackage : audio_serial_port_clocking_pkg

// ==== rtl/audio_serial_port_clocking.sv ====
// Chosen here: the address map and the APB slave port.
`timescale 1ns/100ps
module audio_serial_port_clocking #(
  parameter int HW_TIMEOUT = audio_serial_port_clocking_pkg::HW_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_clock,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe,
  input wire logic frame_clock_in,
  output logic frame_clock_out,
  output logic frame_clock_oe,
  input wire logic serial_data,
  input wire logic strap_master,
  input wire logic strap_halve,
  input wire logic strap_i2s,
  output logic ref_pump_en,
  output logic amp_en,
  output logic mute,
  output logic [3:0] pump_freq,
  output logic [23:0] sample_left,
  output logic [23:0] sample_right,
  output logic sample_valid
);
  if (HW_TIMEOUT < 1) begin : g_timeout_check
    $error("HW_TIMEOUT must be positive");
  end
  typedef enum logic [2:0] {ST_OFF, ST_REF, ST_AMP, ST_MEASURE, ST_RUN} state_e;
  function automatic logic [2:0] classify(input logic [11:0] r);
    if (r == 12'h080 || r == 12'h0C0) classify = {1'b1, audio_serial_port_clocking_pkg::SPD_DOUBLE};
    else if (r == 12'h100 || r == 12'h180) classify = {1'b1, audio_serial_port_clocking_pkg::SPD_SINGLE};
    else if (r == 12'h200 || r == 12'h300) classify = {1'b1, audio_serial_port_clocking_pkg::SPD_HALF};
    else if (r == 12'h400 || r == 12'h600) classify = {1'b1, audio_serial_port_clocking_pkg::SPD_QUARTER};
    else classify = 3'h0;
  endfunction : classify
  function automatic logic [4:0] word_bits(input logic [1:0] w);
    case (w)
      2'h0: word_bits = 5'h10;
      2'h1: word_bits = 5'h12;
      2'h2: word_bits = 5'h14;
      default: word_bits = 5'h18;
    endcase
  endfunction : word_bits
  // Pin synchronisers: master, bit, frame, data, three straps.
  logic [6:0] sync1_r, sync2_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
    end else begin
      sync1_r <= {strap_i2s, strap_halve, strap_master, serial_data, frame_clock_in,
                  bit_clock_in, master_clock};
      sync2_r <= sync1_r;
    end
  end
  // Control register and mode decision.
  logic [15:0] ctrl_r;
  logic [31:0] hw_cnt_r;
  logic [1:0] strap_cnt_r;
  logic decided_r, hw_mode_r, strap_master_r, wr_en;
  assign wr_en = psel && penable && pready && pwrite;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= audio_serial_port_clocking_pkg::CTRL_RST;
    end else if (wr_en && paddr == audio_serial_port_clocking_pkg::CTRL_OFF && !hw_mode_r) begin
      ctrl_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      decided_r <= 1'b0;
      hw_mode_r <= 1'b0;
      hw_cnt_r <= 32'h0;
    end else if (!decided_r) begin
      hw_cnt_r <= hw_cnt_r + 32'h1;
      if (wr_en && paddr == audio_serial_port_clocking_pkg::CTRL_OFF) begin
        decided_r <= 1'b1;
      end else if (hw_cnt_r >= 32'(HW_TIMEOUT - 1)) begin
        decided_r <= 1'b1;
        hw_mode_r <= 1'b1;
      end
    end
  end

  // Strap caught once the synchroniser has settled after release.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_cnt_r <= 2'h0;
      strap_master_r <= 1'b0;
    end else if (strap_cnt_r != 2'h3) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == 2'h2) strap_master_r <= sync2_r[4];
    end
  end
  logic pdn_eff, is_master, halve, auto_det;
  logic [1:0] sw_speed, fmt, wl;
  // Undecided mode, or the software power-down bit, holds power-down.
  assign pdn_eff = !decided_r || (!hw_mode_r && ctrl_r[audio_serial_port_clocking_pkg::PDN_BIT]);
  assign is_master = hw_mode_r ? strap_master_r : ctrl_r[audio_serial_port_clocking_pkg::MASTER_BIT];
  assign halve = hw_mode_r ? sync2_r[5] : ctrl_r[audio_serial_port_clocking_pkg::HALVE_BIT];
  assign auto_det = hw_mode_r || ctrl_r[audio_serial_port_clocking_pkg::AUTO_BIT];
  assign sw_speed = ctrl_r[audio_serial_port_clocking_pkg::SPEED_LSB +: 2];
  assign fmt = hw_mode_r ? (sync2_r[6] ? audio_serial_port_clocking_pkg::FMT_I2S
                                       : audio_serial_port_clocking_pkg::FMT_LJ)
                         : ctrl_r[audio_serial_port_clocking_pkg::FMT_LSB +: 2];
  assign wl = hw_mode_r ? 2'h3 : ctrl_r[audio_serial_port_clocking_pkg::WL_LSB +: 2];
  // Internal master clock tick, every second edge when halved.
  logic mclk_prev_r, halve_ph_r, tick, mclk_valid_r;
  logic [6:0] loss_cnt_r;
  assign tick = sync2_r[0] && !mclk_prev_r && (!halve || halve_ph_r);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mclk_prev_r <= 1'b0;
      halve_ph_r <= 1'b0;
      loss_cnt_r <= 7'h00;
      mclk_valid_r <= 1'b0;
    end else begin
      mclk_prev_r <= sync2_r[0];
      if (sync2_r[0] && !mclk_prev_r) begin
        halve_ph_r <= !halve_ph_r;
        loss_cnt_r <= 7'h00;
        mclk_valid_r <= 1'b1;
      end else if (loss_cnt_r == 7'(audio_serial_port_clocking_pkg::MCLK_LOSS_CYC)) begin
        mclk_valid_r <= 1'b0;
      end else begin
        loss_cnt_r <= loss_cnt_r + 7'h01;
      end
    end
  end
  // Frame period measurement in internal master clock ticks.
  logic frm_prev_r, bclk_prev_r, rx_frame, rx_bclk, seen_edge_r, meas_done_r;
  logic [11:0] meas_cnt_r, ratio_r;
  logic [2:0] det_r;
  state_e state_r;
  assign rx_frame = is_master ? frame_clock_out : sync2_r[2];
  assign rx_bclk = is_master ? bit_clock_out : sync2_r[1];
  // Ticks counted between two rising frame edges.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frm_prev_r <= 1'b0;
      meas_cnt_r <= 12'h000;
      ratio_r <= 12'h000;
      seen_edge_r <= 1'b0;
      meas_done_r <= 1'b0;
      det_r <= 3'h0;
    end else begin
      frm_prev_r <= rx_frame;
      if (state_r == ST_OFF || meas_cnt_r == audio_serial_port_clocking_pkg::FRAME_MAX_TICKS) begin
        seen_edge_r <= 1'b0;
        meas_done_r <= 1'b0;
        meas_cnt_r <= 12'h000;
      end else if (rx_frame && !frm_prev_r) begin
        seen_edge_r <= 1'b1;
        meas_cnt_r <= 12'h000;
        if (seen_edge_r) begin
          ratio_r <= meas_cnt_r;
          meas_done_r <= 1'b1;
          det_r <= classify(meas_cnt_r);
        end
      end else if (tick) begin
        meas_cnt_r <= meas_cnt_r + 12'h001;
      end
    end
  end
  logic [1:0] speed_eff;
  // Hardware master single speed; else field or detection.
  assign speed_eff = (hw_mode_r && is_master) ? audio_serial_port_clocking_pkg::SPD_SINGLE :
                     (auto_det && !is_master && det_r[2]) ? det_r[1:0] : sw_speed;
  // Master clocks are taps of a tick counter: 64 bit clocks per frame.
  logic [9:0] gen_cnt_r;
  logic [3:0] bclk_tap;
  assign bclk_tap = {2'h0, ~speed_eff};
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      gen_cnt_r <= 10'h000;
      bit_clock_out <= 1'b0;
      frame_clock_out <= 1'b0;
      bit_clock_oe <= 1'b0;
      frame_clock_oe <= 1'b0;
    end else begin
      if (pdn_eff || !is_master) gen_cnt_r <= 10'h000;
      else if (tick) gen_cnt_r <= gen_cnt_r + 10'h001;
      bit_clock_out <= gen_cnt_r[bclk_tap];
      // Frame toggles twice per frame; left low for I2S.
      frame_clock_out <= gen_cnt_r[bclk_tap + 4'h6] ^ (fmt != audio_serial_port_clocking_pkg::FMT_I2S);
      bit_clock_oe <= is_master && !ctrl_r[audio_serial_port_clocking_pkg::TRI_BIT];
      frame_clock_oe <= is_master && !ctrl_r[audio_serial_port_clocking_pkg::TRI_BIT];
    end
  end

  // Start-up sequence.
  logic [8:0] wait_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_OFF;
      wait_r <= 9'h000;
    end else if (pdn_eff || !mclk_valid_r) begin
      state_r <= ST_OFF;
      wait_r <= 9'h000;
    end else begin
      wait_r <= wait_r + 9'h001;
      case (state_r)
        ST_OFF: begin
          state_r <= ST_REF;
          wait_r <= 9'h000;
        end
        // Reference and pump first, then amplifiers.
        ST_REF: if (wait_r == 9'(audio_serial_port_clocking_pkg::REF_SETTLE_CYC - 1)) begin
          state_r <= ST_AMP;
          wait_r <= 9'h000;
        end
        ST_AMP: if (wait_r == 9'(audio_serial_port_clocking_pkg::AMP_SETTLE_CYC - 1)) begin
          state_r <= ST_MEASURE;
        end
        // Run only after a measured frame.
        ST_MEASURE: if (meas_done_r) state_r <= ST_RUN;
        default: if (!meas_done_r) state_r <= ST_MEASURE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_pump_en <= 1'b0;
      amp_en <= 1'b0;
      mute <= 1'b1;
      pump_freq <= 4'h0;
    end else begin
      ref_pump_en <= state_r != ST_OFF;
      amp_en <= state_r == ST_AMP || state_r == ST_MEASURE || state_r == ST_RUN;
      mute <= state_r != ST_RUN;
      pump_freq <= ctrl_r[audio_serial_port_clocking_pkg::CPF_LSB +: 4];
    end
  end
  // Serial receive; a frame level change seen at a bit edge ends a word.
  logic [23:0] shift_r, word;
  logic [4:0] bit_cnt_r;
  logic frm_at_bit_r, left_done;
  assign word = shift_r & ~(24'hFFFFFF << word_bits(wl));
  assign left_done = frm_at_bit_r ^ (fmt == audio_serial_port_clocking_pkg::FMT_I2S);
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      bclk_prev_r <= 1'b0;
      shift_r <= 24'h000000;
      bit_cnt_r <= 5'h00;
      frm_at_bit_r <= 1'b0;
      sample_left <= 24'h000000;
      sample_right <= 24'h000000;
      sample_valid <= 1'b0;
    end else begin
      bclk_prev_r <= rx_bclk;
      sample_valid <= 1'b0;
      // Data taken on the bit clock rising edge.
      if (rx_bclk && !bclk_prev_r && state_r == ST_RUN) begin
        frm_at_bit_r <= rx_frame;
        if (rx_frame != frm_at_bit_r) begin
          if (left_done) sample_left <= word;
          else sample_right <= word;
          sample_valid <= !left_done;
          // I2S skips one bit; the others take the first.
          bit_cnt_r <= (fmt == audio_serial_port_clocking_pkg::FMT_I2S) ? 5'h00 : 5'h01;
          shift_r <= (fmt == audio_serial_port_clocking_pkg::FMT_I2S) ? 24'h000000
                     : {23'h000000, sync2_r[3]};
        end else if (fmt == audio_serial_port_clocking_pkg::FMT_RJ
                     || bit_cnt_r < word_bits(wl)) begin
          shift_r <= {shift_r[22:0], sync2_r[3]};
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
      end
    end
  end

  // APB slave: one-cycle access, unmapped addresses flag an error.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        if (paddr == audio_serial_port_clocking_pkg::CTRL_OFF) begin
          prdata <= {16'h0000, ctrl_r};
        end else if (paddr == audio_serial_port_clocking_pkg::STATUS_OFF) begin
          prdata <= {20'h00000, det_r, speed_eff, mclk_valid_r, 1'b0, state_r,
                     hw_mode_r, decided_r};
        end else if (paddr == audio_serial_port_clocking_pkg::RATIO_OFF) begin
          prdata <= {20'h00000, ratio_r};
        end else if (paddr == audio_serial_port_clocking_pkg::LEFT_OFF) begin
          prdata <= {8'h00, sample_left};
        end else if (paddr == audio_serial_port_clocking_pkg::RIGHT_OFF) begin
          prdata <= {8'h00, sample_right};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule : audio_serial_port_clocking

// ==== bench/audio_serial_port_clocking_monitor.sv ====
`timescale 1ns/100ps
module audio_serial_port_clocking_monitor #(
  parameter int HW_TIMEOUT = audio_serial_port_clocking_pkg::HW_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_clock_oe,
  input wire logic frame_clock_oe,
  input wire logic ref_pump_en,
  input wire logic amp_en,
  input wire logic mute,
  input wire logic [3:0] pump_freq,
  input wire logic sample_valid
);
  logic [9:0] ref_cnt_r;
  logic [9:0] amp_cnt_r;
  logic [3:0] pump_r;
  logic wr_ctrl;
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == 8'h00;
  // Counts saturate so a long run never wraps back below the settle figure.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_cnt_r <= 10'h000;
      amp_cnt_r <= 10'h000;
    end else begin
      ref_cnt_r <= ref_pump_en ? ref_cnt_r + {9'h000, ~ref_cnt_r[9]} : 10'h000;
      amp_cnt_r <= amp_en ? amp_cnt_r + {9'h000, ~amp_cnt_r[9]} : 10'h000;
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pump_r <= audio_serial_port_clocking_pkg::CTRL_RST[15:12];
    end else if (wr_ctrl) begin
      pump_r <= pwdata[15:12];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  AST_APB_ANSWER: assert property (psel && !penable |=> pready)
    else $error("No ready after setup.");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("Ready held too long.");
  AST_APB_MAP: assert property (
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h10))
    else $error("Wrong slave error.");
  AST_TRISTATE: assert property (
    wr_ctrl && pwdata[6] |-> ##2 !bit_clock_oe && !frame_clock_oe)
    else $error("Clock outputs still driven.");
  AST_OE_PAIR: assert property (bit_clock_oe == frame_clock_oe)
    else $error("Clock enables differ.");
  AST_MUTE: assert property (!mute |-> amp_en && ref_pump_en)
    else $error("Unmuted while not powered.");
  AST_AMP_AFTER_REF: assert property ($rose(amp_en) |-> ref_cnt_r >= 10'h0FF)
    else $error("Amplifier before reference settled.");
  AST_RUN_AFTER_AMP: assert property ($fell(mute) |-> amp_cnt_r >= 10'h0FF)
    else $error("Run before amplifier settled.");
  AST_PUMP_SRC: assert property (
    $changed(pump_freq) && $past(arst_n, 2) |-> pump_freq == pump_r)
    else $error("Pump setting not from register.");
  AST_VALID_GAP: assert property (sample_valid |=> !sample_valid [*8])
    else $error("Sample pairs too close.");
  cover property ($fell(mute));
  cover property (sample_valid);
  cover property (pready && pslverr);
  cover property (wr_ctrl && pwdata[6]);
endmodule : audio_serial_port_clocking_monitor

bind audio_serial_port_clocking audio_serial_port_clocking_monitor #(
  .HW_TIMEOUT(HW_TIMEOUT)
) u_monitor (
  .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .bit_clock_oe, .frame_clock_oe, .ref_pump_en, .amp_en, .mute, .pump_freq, .sample_valid
);

// ==== bench/audio_source_model.sv ====
`timescale 1ns/100ps
module audio_source_model (
  input wire logic run,
  input wire logic [23:0] left,
  input wire logic [23:0] right,
  output logic master_clock,
  output logic bit_clock,
  output logic frame_clock,
  output logic serial_data
);
  logic [47:0] word;
  initial begin
    {master_clock, bit_clock, frame_clock, serial_data} = 4'h0;
    forever #40 master_clock = ~master_clock;
  end
  always begin
    wait (run);
    word = {left, right};
    for (int i = 0; i < 64; i++) begin
      frame_clock = i < 32;
      serial_data = i % 32 < 24 ? word[47 - i % 32 - 24 * (i / 32)] : ~serial_data;
      repeat (2) @(posedge master_clock);
      bit_clock = 1'b1;
      repeat (2) @(posedge master_clock);
      bit_clock = 1'b0;
    end
  end
endmodule : audio_source_model

// ==== bench/tb_audio_serial_port_clocking.sv ====
`timescale 1ns/100ps
module tb_audio_serial_port_clocking;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, run, q_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, w;
  logic master_clock, bit_clock_in, frame_clock_in, serial_data, strap_master, strap_halve;
  logic bit_clock_out, bit_clock_oe, frame_clock_out, frame_clock_oe, strap_i2s;
  logic ref_pump_en, amp_en, mute, sample_valid;
  logic [3:0] pump_freq;
  logic [23:0] sample_left, sample_right, lw, rw;
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int mc = 0;
  int a;
  audio_serial_port_clocking #(.HW_TIMEOUT(200)) u_dut (
    .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .master_clock, .bit_clock_in, .bit_clock_out, .bit_clock_oe,
    .frame_clock_in, .frame_clock_out, .frame_clock_oe, .serial_data, .strap_master,
    .strap_halve, .strap_i2s, .ref_pump_en, .amp_en, .mute, .pump_freq,
    .sample_left, .sample_right, .sample_valid
  );
  audio_source_model u_src (
    .run, .left(lw), .right(rw), .master_clock, .bit_clock(bit_clock_in),
    .frame_clock(frame_clock_in), .serial_data
  );
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge master_clock) mc++;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    q_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : apb
  initial begin
    {arst_n, psel, penable, pwrite, run} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {strap_master, strap_halve, strap_i2s} = 3'h7;
    {lw, rw} = 48'h0;
    a = $urandom(32'hFE0D);
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (300) @(posedge core_clk);
    apb(1'b0, 8'h04, 32'h0);
    chk("hw_mode", 32'h1, {31'h0, q[1]});
    chk("hw_oe", 32'h1, {31'h0, bit_clock_oe});
    @(posedge frame_clock_out);
    a = mc;
    @(posedge frame_clock_out);
    chk("hw_ratio", 32'h1, {31'h0, (mc - a) inside {[511:513]}});
    @(posedge core_clk);
    arst_n <= 1'b0;
    strap_halve <= 1'b0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    chk("rst_mute", 32'h1, {31'h0, mute});
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl_rst", {16'h0, audio_serial_port_clocking_pkg::CTRL_RST}, q);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, q_err});
    w = {16'h0, 4'($urandom), 12'h629};
    apb(1'b1, 8'h00, w);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", w, q);
    chk("pump", {28'h0, w[15:12]}, {28'h0, pump_freq});
    apb(1'b0, 8'h04, 32'h0);
    chk("sw_mode", 32'h1, {30'h0, q[1:0]});
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h00, w | (i == 0 ? 32'h42 : i == 1 ? 32'h2 : 32'h0));
      chk("oe", {31'h0, i == 1}, {31'h0, bit_clock_oe});
    end
    run <= 1'b1;
    repeat (100) @(posedge core_clk);
    apb(1'b1, 8'h00, w ^ 32'h1);
    @(posedge amp_en);
    #1;
    chk("amp_mute", 32'h1, {31'h0, mute & ref_pump_en});
    wait (mute === 1'b0);
    @(posedge core_clk);
    apb(1'b0, 8'h08, 32'h0);
    chk("ratio", 32'h1, {31'h0, q[11:0] inside {[255:257]}});
    apb(1'b0, 8'h04, 32'h0);
    chk("speed", {30'h0, audio_serial_port_clocking_pkg::SPD_SINGLE}, {30'h0, q[8:7]});
    chk("state", 32'h4, {29'h0, q[4:2]});
    for (int i = 0; i < 5; i++) begin
      @(posedge sample_valid);
      lw = i == 0 ? 24'hFFFFFF : 24'($urandom);
      rw = i == 0 ? 24'h000001 : 24'($urandom);
      repeat (2) @(posedge sample_valid);
      #1;
      chk("left", {8'h0, lw}, {8'h0, sample_left});
      chk("right", {8'h0, rw}, {8'h0, sample_right});
    end
    @(posedge core_clk);
    apb(1'b1, 8'h00, ((w ^ 32'h1) & 32'hFFFFFFC7) | 32'h30);
    apb(1'b0, 8'h04, 32'h0);
    chk("sw_speed", {30'h0, audio_serial_port_clocking_pkg::SPD_DOUBLE}, {30'h0, q[8:7]});
    apb(1'b1, 8'h00, w);
    @(posedge core_clk);
    chk("pd_mute", 32'h1, {31'h0, mute});
    results();
  end
endmodule : tb_audio_serial_port_clocking
